// file: hw/vphy_status_pkg.sv
package vphy_status_pkg;

    // ==============================================================
    // Register map
    localparam logic [11:0] AN_EXP_OFFSET = 12'h1d8;
    localparam logic [11:0] SPECIAL_CS_OFFSET = 12'h1dc;
    localparam logic [4:0] AN_EXP_INDEX = 5'h06;
    localparam logic [4:0] SPECIAL_CS_INDEX = 5'h1f;

    // ==============================================================
    // Expansion register fields
    localparam int EXP_PAR_FAULT_BIT = 4;
    localparam int EXP_PARTNER_NP_BIT = 3;
    localparam int EXP_LOCAL_NP_BIT = 2;
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_PARTNER_AN_BIT = 0;

    // ==============================================================
    // Special control/status fields
    localparam int SCS_LOOPBACK_BIT = 14;
    localparam int SCS_COL_TEST_BIT = 7;
    localparam int SCS_SPDPX_LSB = 2;
    localparam logic SCS_LOOPBACK_RESET = 1'b0;
    localparam logic SCS_COL_TEST_RESET = 1'b0;

    // ==============================================================
    // Ability codes, bits 8..5 of the partner ability word
    localparam logic [3:0] ABIL_10_FULL = 4'h2;
    localparam logic [3:0] ABIL_100_FULL = 4'h8;
    localparam logic [3:0] ABIL_10_HALF = 4'h1;
    localparam logic [3:0] ABIL_100_HALF = 4'h4;
    localparam int ABIL_BIT_100_FULL = 3;
    localparam int ABIL_BIT_100_HALF = 2;
    localparam int ABIL_BIT_10_FULL = 1;

    // ==============================================================
    // Speed/duplex indication codes (bit 2 = 10, bit 3 = 100, bit 4 = full)
    localparam logic [2:0] SPDPX_10_HALF = 3'h1;
    localparam logic [2:0] SPDPX_100_HALF = 3'h2;
    localparam logic [2:0] SPDPX_10_FULL = 3'h5;
    localparam logic [2:0] SPDPX_100_FULL = 3'h6;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // System CSR request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } csr_req_t;

    // Serial management request, 16-bit view
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] index;
        logic [15:0] wdata;
    } mgmt_req_t;

    // Negotiation outcome
    typedef struct packed {
        logic done;
        logic failed;
        logic [3:0] partner_ability;
        logic [2:0] spdpx;
    } an_result_t;

    typedef enum logic [1:0] {
        AN_IDLE,
        AN_RUN,
        AN_DONE
    } an_state_t;

endpackage

// file: hw/emulated_partner.sv
`timescale 1ns/1ps
`default_nettype none

module emulated_partner
    import vphy_status_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic duplex_pin,
    input wire logic duplex_pol_strap,
    input wire logic speed_strap,
    input wire logic [3:0] local_adv,
    input wire logic an_restart,
    output an_result_t result
);

    // ==============================================================
    // Strap capture
    // Straps are caught by the first clocked edge after reset release
    logic strap_taken_reg;
    logic duplex_pol_reg;
    logic speed_reg;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            strap_taken_reg <= 1'b0;
            duplex_pol_reg <= 1'b0;
            speed_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            duplex_pol_reg <= duplex_pol_strap;
            speed_reg <= speed_strap;
        end
    end

    // ==============================================================
    // Partner ability and highest common mode
    wire logic dup_match = (duplex_pin == duplex_pol_reg);
    wire logic [3:0] full_code = speed_reg ? ABIL_100_FULL : ABIL_10_FULL;
    wire logic [3:0] half_code = speed_reg ? ABIL_100_HALF : ABIL_10_HALF;
    wire logic [3:0] partner_next = dup_match ? full_code : half_code;
    wire logic [3:0] common = partner_next & local_adv;
    wire logic [2:0] best_spdpx =
        common[ABIL_BIT_100_FULL] ? SPDPX_100_FULL :
        common[ABIL_BIT_100_HALF] ? SPDPX_100_HALF :
        common[ABIL_BIT_10_FULL] ? SPDPX_10_FULL : SPDPX_10_HALF;

    // ==============================================================
    // Negotiation sequencer: runs once after straps are taken, then again on each restart from done
    an_state_t state_reg;
    an_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            AN_IDLE: begin
                if (strap_taken_reg) begin
                    state_next = AN_RUN;
                end
            end
            AN_RUN: begin
                state_next = AN_DONE;
            end
            AN_DONE: begin
                if (an_restart) begin
                    state_next = AN_RUN;
                end
            end
            default: begin
                state_next = AN_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= AN_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Result latched at the end of a run; ability follows the pin live
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            result <= '0;
        end else begin
            result.partner_ability <= partner_next;
            result.done <= (state_reg == AN_RUN);
            if (state_reg == AN_RUN) begin
                result.failed <= (common == 4'h0);
                result.spdpx <= best_spdpx;
            end
        end
    end

endmodule // emulated_partner

`default_nettype wire

// file: hw/vphy_autoneg_status.sv
// Notes on behaviour
// - Duplex pin equal to polarity strap: partner offers 10 full or 100 full.
// - Duplex pin differing from strap: partner offers 10 half or 100 half.
// - Parallel detection fault flag always reads zero.
// - Partner next-page-able flag is read-only zero.
// - Local next-page-able flag is read-only zero.
// - Page-received flag latches high and clears on read.
// - Page-received cleared by reset, set once negotiation has run.
// - Partner negotiation-able unless no common ability bits.
// - Each register is a 32-bit word, upper half reads zero.
// - Management access sees each register as 16 bits.
// - Expansion register at offset 1D8h and management index 6.
// - Special control/status at offset 1DCh and management index 31.
// - Collision-test bit drives collision to port 0 while it transmits.
// - Loopback bit returns port 0 traffic; software enables own-receive too.
// - Speed/duplex field shows negotiation result or forced control bits.
`timescale 1ns/1ps
`default_nettype none

module vphy_autoneg_status
    import vphy_status_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire csr_req_t csr_req,
    output logic [31:0] csr_rdata,
    input wire mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    input wire logic duplex_pin,
    input wire logic duplex_pol_strap,
    input wire logic speed_strap,
    input wire logic [3:0] local_adv,
    input wire logic an_restart,
    input wire logic autoneg_enable_bit,
    input wire logic speed_sel,
    input wire logic duplex_mode,
    input wire logic port0_transmitting,
    output logic [3:0] partner_ability,
    output logic port0_collision,
    output logic far_loopback_en
);

    // ==============================================================
    // Negotiation engine
    an_result_t an_res;

    emulated_partner u_partner (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .duplex_pin(duplex_pin),
        .duplex_pol_strap(duplex_pol_strap),
        .speed_strap(speed_strap),
        .local_adv(local_adv),
        .an_restart(an_restart),
        .result(an_res)
    );

    // ==============================================================
    // Address decode for both access paths
    wire logic csr_hit_exp = (csr_req.addr == AN_EXP_OFFSET);
    wire logic csr_hit_scs = (csr_req.addr == SPECIAL_CS_OFFSET);
    wire logic mg_hit_exp = (mgmt_req.index == AN_EXP_INDEX);
    wire logic mg_hit_scs = (mgmt_req.index == SPECIAL_CS_INDEX);
    wire logic exp_read = (csr_req.rd && csr_hit_exp) || (mgmt_req.rd && mg_hit_exp);
    wire logic csr_scs_wr = csr_req.wr && csr_hit_scs;
    wire logic mg_scs_wr = mgmt_req.wr && mg_hit_scs;

    // System path wins when both write in one cycle
    wire logic [15:0] scs_wdata = csr_scs_wr ? csr_req.wdata[15:0] : mgmt_req.wdata;
    wire logic scs_wr = csr_scs_wr || mg_scs_wr;

    // ==============================================================
    // Page received: set by a finished run, cleared by reading
    logic page_rx_reg;
    logic page_rx_next;

    // Set wins over a same-cycle read so a fresh page is never lost
    assign page_rx_next = an_res.done ? 1'b1 : (exp_read ? 1'b0 : page_rx_reg);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            page_rx_reg <= 1'b0;
        end else begin
            page_rx_reg <= page_rx_next;
        end
    end

    // ==============================================================
    // Loopback and collision-test controls
    logic loopback_reg;
    logic col_test_reg;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            loopback_reg <= SCS_LOOPBACK_RESET;
            col_test_reg <= SCS_COL_TEST_RESET;
        end else if (scs_wr) begin
            loopback_reg <= scs_wdata[SCS_LOOPBACK_BIT];
            col_test_reg <= scs_wdata[SCS_COL_TEST_BIT];
        end
    end

    // Collision only during port 0 transmit; intended for loopback use
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            port0_collision <= 1'b0;
            far_loopback_en <= 1'b0;
        end else begin
            port0_collision <= col_test_reg && port0_transmitting;
            far_loopback_en <= loopback_reg;
        end
    end

    // ==============================================================
    // Speed/duplex indication
    wire logic [2:0] forced_spdpx =
        speed_sel ? (duplex_mode ? SPDPX_100_FULL : SPDPX_100_HALF)
                  : (duplex_mode ? SPDPX_10_FULL : SPDPX_10_HALF);
    wire logic [2:0] spdpx = autoneg_enable_bit ? an_res.spdpx : forced_spdpx;

    // ==============================================================
    // Register images, 16 significant bits each
    logic [15:0] exp_image;
    logic [15:0] scs_image;

    always_comb begin
        exp_image = 16'h0000;
        exp_image[EXP_PAR_FAULT_BIT] = 1'b0;
        exp_image[EXP_PARTNER_NP_BIT] = 1'b0;
        exp_image[EXP_LOCAL_NP_BIT] = 1'b0;
        exp_image[EXP_PAGE_RX_BIT] = page_rx_reg;
        exp_image[EXP_PARTNER_AN_BIT] = !an_res.failed;
    end

    always_comb begin
        scs_image = 16'h0000;
        scs_image[SCS_LOOPBACK_BIT] = loopback_reg;
        scs_image[SCS_COL_TEST_BIT] = col_test_reg;
        scs_image[SCS_SPDPX_LSB +: 3] = spdpx;
    end

    // Read mux; unmapped addresses read zero
    wire logic [15:0] csr_sel =
        csr_hit_exp ? exp_image : (csr_hit_scs ? scs_image : 16'h0000);
    wire logic [15:0] mg_sel =
        mg_hit_exp ? exp_image : (mg_hit_scs ? scs_image : 16'h0000);

    // ==============================================================
    // Registered read data, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            csr_rdata <= ZERO_WORD;
            mgmt_rdata <= 16'h0000;
            partner_ability <= 4'h0;
        end else begin
            if (csr_req.rd) begin
                csr_rdata <= {ZERO_WORD[31:16], csr_sel};
            end
            if (mgmt_req.rd) begin
                mgmt_rdata <= mg_sel;
            end
            partner_ability <= an_res.partner_ability;
        end
    end

endmodule // vphy_autoneg_status

`default_nettype wire

// file: dv/vphy_autoneg_status_properties.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// Port checker
module vphy_autoneg_status_properties
    import vphy_status_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire csr_req_t csr_req,
    input wire logic [31:0] csr_rdata,
    input wire mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic duplex_pin,
    input wire logic duplex_pol_strap,
    input wire logic speed_strap,
    input wire logic an_restart,
    input wire logic autoneg_enable_bit,
    input wire logic speed_sel,
    input wire logic duplex_mode,
    input wire logic port0_transmitting,
    input wire logic [3:0] partner_ability,
    input wire logic port0_collision,
    input wire logic far_loopback_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Address decodes of the watched requests
    wire logic rd_exp = csr_req.rd && (csr_req.addr == AN_EXP_OFFSET);
    wire logic rd_scs = csr_req.rd && (csr_req.addr == SPECIAL_CS_OFFSET);
    wire logic rd_mexp = mgmt_req.rd && (mgmt_req.index == AN_EXP_INDEX);

    // Restart quiet long enough that no run can set the page flag
    sequence s_quiet;
        (rstn && !an_restart)[*4];
    endsequence
    sequence s_two_reads;
        (rd_exp && !an_restart) ##1 (rd_exp && !an_restart);
    endsequence
    sequence s_scs_write;
        csr_req.wr && (csr_req.addr == SPECIAL_CS_OFFSET);
    endsequence

    a_upper_zero: assert property (csr_rdata[31:16] == 16'h0)
        else $error("upper half of read data not zero");
    a_exp_csr_zero: assert property (rd_exp |=> csr_rdata[31:2] == 30'h0)
        else $error("expansion read has fixed bits set");
    a_exp_mgmt_zero: assert property (rd_mexp |=> mgmt_rdata[15:2] == 14'h0)
        else $error("serial expansion read has fixed bits set");
    a_unmapped_zero: assert property (csr_req.rd && !rd_exp && !rd_scs
        |=> csr_rdata == ZERO_WORD)
        else $error("unmapped read not zero");
    a_spdpx_forced: assert property (rd_scs && !autoneg_enable_bit |=> csr_rdata[4:2] ==
        {$past(duplex_mode), $past(speed_sel), !$past(speed_sel)})
        else $error("forced speed duplex code wrong");
    // Ability output lags the live pin by two flops; straps held steady out of reset
    a_partner_map: assert property ($past(rstn, 3) && $past(rstn, 2) && $past(rstn)
        |-> partner_ability == (($past(duplex_pin, 2) == duplex_pol_strap) ?
        (speed_strap ? ABIL_100_FULL : ABIL_10_FULL) :
        (speed_strap ? ABIL_100_HALF : ABIL_10_HALF)))
        else $error("partner ability wrong");
    a_page_clear: assert property (s_quiet ##1 s_two_reads |=> !csr_rdata[1])
        else $error("page flag not cleared by read");
    a_col_quiet: assert property (!port0_transmitting |=> !port0_collision)
        else $error("collision without transmit");
    a_loop_follow: assert property (s_scs_write
        |-> ##2 far_loopback_en == $past(csr_req.wdata[14], 2))
        else $error("loopback output does not follow write");
endmodule // vphy_autoneg_status_properties

bind vphy_autoneg_status vphy_autoneg_status_properties chk (.*);

`default_nettype wire

// file: dv/mgmt_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// Management host: one access per call, pulses for one cycle
module mgmt_host_model
    import vphy_status_pkg::*;
(
    input wire logic sys_clk,
    output mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata
);
    initial mgmt_req = '0;

    // Data is taken after release; it holds until the next read
    task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
        output logic [15:0] rd);
        @(negedge sys_clk);
        mgmt_req <= {~wr, wr, idx, wd};
        @(negedge sys_clk);
        mgmt_req <= '0;
        rd = mgmt_rdata;
    endtask
endmodule // mgmt_host_model

`default_nettype wire

// file: dv/vphy_autoneg_status_test.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// Bench top
module vphy_autoneg_status_test
    import vphy_status_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn, duplex_pin, duplex_pol_strap, speed_strap, an_restart;
    logic autoneg_enable_bit, speed_sel, duplex_mode, port0_transmitting;
    logic port0_collision, far_loopback_en, ok;
    logic [3:0] local_adv, partner_ability, pa, adv;
    logic [31:0] csr_rdata, rd, r;
    logic [15:0] mgmt_rdata, mrd;
    csr_req_t csr_req;
    mgmt_req_t mgmt_req;
    int err_count = 0;
    int n_compared = 0;
    integer seed = 32'h20acc8c1;

    always #2.5 sys_clk = ~sys_clk;

    vphy_autoneg_status uut (.*);
    mgmt_host_model host (.sys_clk(sys_clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata));

    // =====================================================
    // Expectations
    function automatic logic [3:0] f_pa(input logic pin, input logic pol, input logic spd);
        return (pin == pol) ? (spd ? 4'h8 : 4'h2) : (spd ? 4'h4 : 4'h1);
    endfunction
    function automatic logic [2:0] f_an(input logic [3:0] c);
        return c[3] ? 3'h6 : c[2] ? 3'h2 : c[1] ? 3'h5 : 3'h1;
    endfunction
    function automatic logic [31:0] f_scs(input logic lb, input logic ct, input logic [2:0] sp);
        return {17'h0, lb, 6'h0, ct, 2'h0, sp, 2'h0};
    endfunction

    // =====================================================
    // Shared tasks
    task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic csr(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] q);
        @(negedge sys_clk);
        csr_req <= {~wr, wr, a, wd};
        @(negedge sys_clk);
        csr_req <= '0;
        q = csr_rdata;
    endtask
    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard well beyond the whole sequence
    initial begin
        #400000;
        err_count++;
        print_verdict();
    end

    // =====================================================
    // Main sequence
    initial begin
        {rstn, duplex_pin, duplex_pol_strap, speed_strap, an_restart} = 5'h0;
        {speed_sel, duplex_mode, port0_transmitting} = 3'h0;
        autoneg_enable_bit = 1'b1;
        local_adv = 4'hf;
        csr_req = '0;
        repeat (5) @(negedge sys_clk);
        // Every strap and pin mix; random advertisement, one with nothing shared
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            rstn <= 1'b0;
            {duplex_pin, speed_strap, duplex_pol_strap} <= i[2:0];
            pa = f_pa(i[2], i[0], i[1]);
            r = $random(seed);
            adv = (i == 5) ? ~pa : r[3:0];
            local_adv <= adv;
            repeat (5) @(negedge sys_clk);
            rstn <= 1'b1;
            repeat (6) @(negedge sys_clk);
            ok = |(adv & pa);
            cmp("partner", {28'h0, pa}, {28'h0, partner_ability});
            csr(1'b0, AN_EXP_OFFSET, 32'h0, rd);
            cmp("expansion", {30'h0, 1'b1, ok}, rd);
            csr(1'b0, SPECIAL_CS_OFFSET, 32'h0, rd);
            cmp("special", f_scs(1'b0, 1'b0, f_an(adv & pa)), rd);
            host.access(1'b0, AN_EXP_INDEX, 16'h0, mrd);
            cmp("serial expansion", {31'h0, ok}, {16'h0, mrd});
            duplex_pin <= ~i[2];
            pa = f_pa(~i[2], i[0], i[1]);
            // Pin reaches the output through two flops: engine result, then port
            repeat (2) @(negedge sys_clk);
            cmp("partner live", {28'h0, pa}, {28'h0, partner_ability});
        end
        // Rerun, then two reads back to back
        an_restart <= 1'b1;
        @(negedge sys_clk);
        an_restart <= 1'b0;
        ok = |(adv & pa);
        repeat (5) @(negedge sys_clk);
        csr_req <= {1'b1, 1'b0, AN_EXP_OFFSET, 32'h0};
        @(negedge sys_clk);
        cmp("page set", {30'h0, 1'b1, ok}, csr_rdata);
        @(negedge sys_clk);
        csr_req <= '0;
        cmp("page clear", {31'h0, ok}, csr_rdata);
        // Forced mode, every speed and duplex pair
        autoneg_enable_bit <= 1'b0;
        for (int j = 0; j < 4; j++) begin
            {speed_sel, duplex_mode} <= j[1:0];
            host.access(1'b0, SPECIAL_CS_INDEX, 16'h0, mrd);
            cmp("forced", f_scs(1'b0, 1'b0, {j[0], j[1], ~j[1]}), {16'h0, mrd});
        end
        // Loopback with collision test; fixed bits must ignore the write
        csr(1'b1, SPECIAL_CS_OFFSET, 32'hffff_ffff, rd);
        csr(1'b0, SPECIAL_CS_OFFSET, 32'h0, rd);
        cmp("special rw", f_scs(1'b1, 1'b1, 3'h6), rd);
        cmp("loopback on", 32'h1, {31'h0, far_loopback_en});
        port0_transmitting <= 1'b1;
        @(negedge sys_clk);
        cmp("collision", 32'h1, {31'h0, port0_collision});
        host.access(1'b1, SPECIAL_CS_INDEX, 16'h0, mrd);
        @(negedge sys_clk);
        cmp("loopback off", 32'h0, {31'h0, far_loopback_en});
        cmp("collision off", 32'h0, {31'h0, port0_collision});
        port0_transmitting <= 1'b0;
        csr(1'b1, AN_EXP_OFFSET, 32'hffff_ffff, rd);
        csr(1'b0, AN_EXP_OFFSET, 32'h0, rd);
        cmp("expansion ro", {31'h0, ok}, rd);
        csr(1'b0, 12'h1e0, 32'h0, rd);
        cmp("unmapped", ZERO_WORD, rd);
        host.access(1'b0, 5'h05, 16'h0, mrd);
        cmp("serial unmapped", ZERO_WORD, {16'h0, mrd});
        print_verdict();
    end
endmodule // vphy_autoneg_status_test

`default_nettype wire
